// [logic/ddrbr_top.sv]
// Purpose: Burst read and write engine of a DDR memory device with AXI4-Lite config.
// Assumes: Pins are sampled by aclk; ck is much slower than aclk.
// Notes:   One read and one write burst in flight; busy engines ignore commands.
//
// The implementer's own choices: the register addresses and register access over AXI4-Lite.
`include "ddrbr_defs.svh"

// Function
// R1: On-the-fly select bit picks chop or full.
// R2: Select bit never used as column address.
// R3: Full burst for fixed eight or select high.
// R4: Chop field forces four-beat chop always.
// R5: Auto-precharge closes bank after the burst.
// R6: Controller spaces precharge after read.
// R7: Read-to-precharge at least four cycles, 7.5ns.
// R8: Controller also honours row active time.
// R9: Reactivate after precharge and row cycle times.
// R10: Write-to-read counted after last data beat.
// R11: Write recovery counted after last data beat.
// R12: Bad data setup only corrupts addressed location.
// R13: Strobe violations never hang the device.
// R14: One byte mask per eight data lines.
// R15: Byte mask ignored during read bursts.
// R16: Controller keeps strobe skew every clock edge.
// R17: Controller meets timing at every strobe edge.
// R18: Read data starts additive plus CAS latency.
// R19: Controller precharges before opening another row.
// R20: Controller activates bank before read or write.
// R21: Write data captured after write latency.
// R22: Two beats per clock, both strobe edges.
module ddrbr_top
    import ddrbr_pkg::*;
(
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic [11:0] awaddr,
    input  wire logic        awvalid,
    output wire logic        awready,
    input  wire logic [31:0] wdata,
    input  wire logic [3:0]  wstrb,
    input  wire logic        wvalid,
    output wire logic        wready,
    output wire logic [1:0]  bresp,
    output wire logic        bvalid,
    input  wire logic        bready,
    input  wire logic [11:0] araddr,
    input  wire logic        arvalid,
    output wire logic        arready,
    output wire logic [31:0] rdata,
    output wire logic [1:0]  rresp,
    output wire logic        rvalid,
    input  wire logic        rready,
    input  wire logic        ck,
    input  wire ddrbr_cmd_t  cmd,
    input  wire logic [15:0] dq_in,
    input  wire logic [1:0]  write_byte_mask,
    input  wire logic        dqs_in,
    output wire logic [15:0] dq_out,
    output wire logic        dq_oe,
    output wire logic        dqs_out,
    output wire logic        dqs_oe
);
    localparam int CW = $bits(ddrbr_cmd_t);
    localparam int SW = CW + 20;

    logic [SW-1:0] s1_q, s2_q;
    logic          ck_p_q, dqs_p_q;
    logic          ck_s, dqs_s, ck_rise, ck_fall, ck_edge, dqs_edge;
    logic [1:0]    dm_s;
    logic [15:0]   dq_s;
    ddrbr_cmd_t    cmd_s;
    logic [15:0]   cfg_q, cfg_d;
    logic [1:0]    bl;
    logic [4:0]    rl, wl;
    logic [15:0]   mem_q [0:511];
    ddrbr_rst_t    r_st_q, r_st_d;
    ddrbr_wst_t    w_st_q, w_st_d;
    logic [4:0]    r_cnt_q, r_cnt_d, r_age_q, r_age_d, w_cnt_q, w_cnt_d, w_age_q, w_age_d;
    logic [3:0]    r_beat_q, r_beat_d, r_len_q, r_len_d, w_beat_q, w_beat_d, w_len_q, w_len_d;
    logic [3:0]    w_win_q, w_win_d;
    logic [2:0]    r_bank_q, r_bank_d, w_bank_q, w_bank_d;
    logic [9:0]    r_col_q, r_col_d, w_col_q, w_col_d;
    logic          r_ap_q, r_ap_d, w_ap_q, w_ap_d;
    logic          r_take, w_take, r_done, w_done, w_store;
    logic [8:0]    w_addr;
    logic [15:0]   dq_out_q, dq_out_d, wr_beats_q, wr_beats_d;
    logic          dqs_out_q, dqs_out_d, dq_oe_q, dq_oe_d;
    logic [7:0]    bank_q, bank_d;
    logic          awready_q, awready_d, bvalid_q, bvalid_d, arready_q, arready_d, rvalid_q, rvalid_d;
    logic [1:0]    bresp_q, bresp_d, rresp_q, rresp_d;
    logic [31:0]   rdata_q, rdata_d;
    logic          wr_hs, rd_hs;

    function automatic logic [3:0] ddrbr_len(input logic [1:0] mode, input logic sel);
        ddrbr_len = (mode == `DDRBR_BL_CHOP || (mode == `DDRBR_BL_OTF && !sel)) ? `DDRBR_LEN_CHOP
                                                                                : `DDRBR_LEN_FULL;
    endfunction : ddrbr_len

    function automatic logic [8:0] ddrbr_addr(input logic [2:0] bk, input logic [9:0] cl_a,
                                              input logic [3:0] len, input logic [3:0] beat);
        ddrbr_addr = (len == `DDRBR_LEN_FULL) ? {bk, cl_a[5:3], beat[2:0]}
                                              : {bk, cl_a[5:3], cl_a[2], beat[1:0]}; // R2
    endfunction : ddrbr_addr

    function automatic logic [1:0] ddrbr_dec(input logic [11:0] a);
        unique case (a[11:2])
            `DDRBR_CFG_OFF:  ddrbr_dec = 2'h0;
            `DDRBR_STAT_OFF: ddrbr_dec = 2'h1;
            `DDRBR_CNT_OFF:  ddrbr_dec = 2'h2;
            default:         ddrbr_dec = 2'h3;
        endcase
    endfunction : ddrbr_dec

    // ----------------------------------------
    // Pin sampling and edge detection.
    // ----------------------------------------
    assign ck_s     = s2_q[SW-1];
    assign dqs_s    = s2_q[SW-2];
    assign dm_s     = s2_q[SW-3 -: 2];
    assign dq_s     = s2_q[SW-5 -: 16];
    assign cmd_s    = ddrbr_cmd_t'(s2_q[CW-1:0]);
    assign ck_rise  = ck_s & ~ck_p_q;
    assign ck_fall  = ~ck_s & ck_p_q;
    assign ck_edge  = ck_s ^ ck_p_q;
    assign dqs_edge = dqs_s ^ dqs_p_q; // R22
    assign bl       = cfg_q[`DDRBR_BL_LSB +: 2];
    assign rl       = {1'b0, cfg_q[`DDRBR_AL_LSB +: 4]} + {1'b0, cfg_q[`DDRBR_CL_LSB +: 4]}; // R18
    assign wl       = {1'b0, cfg_q[`DDRBR_AL_LSB +: 4]} + {1'b0, cfg_q[`DDRBR_CWL_LSB +: 4]}; // R21
    assign r_take   = ck_rise && cmd_s.rd && (r_st_q == R_IDLE);
    assign w_take   = ck_rise && cmd_s.wr && (w_st_q == W_IDLE);
    assign w_store  = (w_st_q == W_DATA) && dqs_edge && (w_beat_q != w_len_q); // R12
    assign w_addr   = ddrbr_addr(w_bank_q, w_col_q, w_len_q, w_beat_q);
    assign wr_hs    = awready_q && awvalid && wvalid;
    assign rd_hs    = arready_q && arvalid;

    // ----------------------------------------
    // Read burst engine.
    // ----------------------------------------
    always_comb
    begin
        r_st_d    = r_st_q;
        r_cnt_d   = r_cnt_q;
        r_age_d   = r_age_q;
        r_beat_d  = r_beat_q;
        r_len_d   = r_len_q;
        r_bank_d  = r_bank_q;
        r_col_d   = r_col_q;
        r_ap_d    = r_ap_q;
        dq_out_d  = dq_out_q;
        dqs_out_d = dqs_out_q;
        dq_oe_d   = dq_oe_q;
        r_done    = 1'b0;
        unique case (r_st_q)
            R_IDLE:
            begin
                if (r_take)
                begin
                    r_len_d  = ddrbr_len(bl, cmd_s.bsel); // R1 R3 R4
                    r_cnt_d  = rl; // R18
                    r_age_d  = 5'h00;
                    r_bank_d = cmd_s.bank;
                    r_col_d  = cmd_s.col;
                    r_ap_d   = cmd_s.ap; // R5
                    r_st_d   = R_WAIT;
                end
            end
            R_WAIT:
            begin
                if (ck_rise)
                begin
                    r_age_d = r_age_q + 5'h01;
                    r_cnt_d = r_cnt_q - 5'h01;
                    if (r_cnt_q == 5'h01)
                    begin
                        dq_out_d  = mem_q[ddrbr_addr(r_bank_q, r_col_q, r_len_q, 4'h0)];
                        dqs_out_d = 1'b1;
                        dq_oe_d   = 1'b1;
                        r_beat_d  = 4'h1;
                        r_st_d    = R_DATA;
                    end
                end
            end
            R_DATA:
            begin
                if (ck_edge)
                begin
                    if (r_beat_q == r_len_q)
                    begin
                        dq_oe_d   = 1'b0;
                        dqs_out_d = 1'b0;
                        r_done    = 1'b1;
                        r_st_d    = R_IDLE;
                    end
                    else
                    begin
                        dq_out_d  = mem_q[ddrbr_addr(r_bank_q, r_col_q, r_len_q, r_beat_q)]; // R22
                        dqs_out_d = ck_s;
                        r_beat_d  = r_beat_q + 4'h1;
                    end
                end
            end
        endcase
    end

    // ----------------------------------------
    // Write burst engine.
    // ----------------------------------------
    always_comb
    begin
        w_st_d     = w_st_q;
        w_cnt_d    = w_cnt_q;
        w_age_d    = w_age_q;
        w_beat_d   = w_beat_q;
        w_win_d    = w_win_q;
        w_len_d    = w_len_q;
        w_bank_d   = w_bank_q;
        w_col_d    = w_col_q;
        w_ap_d     = w_ap_q;
        wr_beats_d = wr_beats_q;
        w_done     = 1'b0;
        unique case (w_st_q)
            W_IDLE:
            begin
                if (w_take)
                begin
                    w_len_d  = ddrbr_len(bl, cmd_s.bsel); // R1 R3 R4
                    w_cnt_d  = wl; // R21
                    w_age_d  = 5'h00;
                    w_bank_d = cmd_s.bank;
                    w_col_d  = cmd_s.col;
                    w_ap_d   = cmd_s.ap; // R5
                    w_st_d   = W_WAIT;
                end
            end
            W_WAIT:
            begin
                if (ck_rise)
                begin
                    w_age_d = w_age_q + 5'h01;
                    w_cnt_d = w_cnt_q - 5'h01;
                end
                if (ck_fall && w_cnt_q == 5'h01)
                begin
                    w_beat_d = 4'h0;
                    w_win_d  = 4'h0;
                    w_st_d   = W_DATA;
                end
            end
            W_DATA:
            begin
                if (w_store)
                begin
                    w_beat_d   = w_beat_q + 4'h1;
                    wr_beats_d = wr_beats_q + 16'h0001;
                end
                if (ck_rise)
                begin
                    w_win_d = w_win_q + 4'h1;
                    if (w_win_q == {1'b0, w_len_q[3:1]}) // R13
                    begin
                        w_done = 1'b1;
                        w_st_d = W_IDLE;
                    end
                end
            end
        endcase
    end

    // ----------------------------------------
    // Bank state and register bus.
    // ----------------------------------------
    always_comb
    begin
        bank_d    = bank_q;
        cfg_d     = cfg_q;
        awready_d = !awready_q && !bvalid_q && awvalid && wvalid;
        arready_d = !arready_q && !rvalid_q && arvalid;
        bvalid_d  = bvalid_q && !bready;
        bresp_d   = bresp_q;
        rvalid_d  = rvalid_q && !rready;
        rresp_d   = rresp_q;
        rdata_d   = rdata_q;
        if (r_done && r_ap_q)
            bank_d[r_bank_q] = 1'b0; // R5
        if (w_done && w_ap_q)
            bank_d[w_bank_q] = 1'b0; // R5
        if (ck_rise && cmd_s.pre && cmd_s.ap)
            bank_d = 8'h00;
        else if (ck_rise && cmd_s.pre)
            bank_d[cmd_s.bank] = 1'b0;
        if (ck_rise && cmd_s.act)
            bank_d[cmd_s.bank] = 1'b1;
        if (wr_hs)
        begin
            bvalid_d = 1'b1;
            bresp_d  = (ddrbr_dec(awaddr) == 2'h3) ? `DDRBR_RESP_ERR : `DDRBR_RESP_OK;
            if (ddrbr_dec(awaddr) == 2'h0 && wstrb[0])
                cfg_d[7:0] = wdata[7:0];
            if (ddrbr_dec(awaddr) == 2'h0 && wstrb[1])
                cfg_d[15:8] = wdata[15:8];
        end
        if (rd_hs)
        begin
            rvalid_d = 1'b1;
            rresp_d  = `DDRBR_RESP_OK;
            unique case (ddrbr_dec(araddr))
                2'h0: rdata_d = {16'h0000, cfg_q};
                2'h1: rdata_d = {22'h00_0000, w_st_q != W_IDLE, r_st_q != R_IDLE, bank_q};
                2'h2: rdata_d = {16'h0000, wr_beats_q};
                2'h3:
                begin
                    rdata_d = 32'h0000_0000;
                    rresp_d = `DDRBR_RESP_ERR;
                end
            endcase
        end
    end

    // ----------------------------------------
    // State registers.
    // ----------------------------------------
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s1_q <= '0; s2_q <= '0; ck_p_q <= 1'b0; dqs_p_q <= 1'b0;
            cfg_q <= `DDRBR_CFG_RST; bank_q <= 8'h00; wr_beats_q <= 16'h0000;
            r_st_q <= R_IDLE; r_cnt_q <= 5'h00; r_age_q <= 5'h00; r_beat_q <= 4'h0;
            r_len_q <= `DDRBR_LEN_FULL; r_bank_q <= 3'h0; r_col_q <= 10'h000; r_ap_q <= 1'b0;
            w_st_q <= W_IDLE; w_cnt_q <= 5'h00; w_age_q <= 5'h00; w_beat_q <= 4'h0; w_win_q <= 4'h0;
            w_len_q <= `DDRBR_LEN_FULL; w_bank_q <= 3'h0; w_col_q <= 10'h000; w_ap_q <= 1'b0;
            dq_out_q <= 16'h0000; dqs_out_q <= 1'b0; dq_oe_q <= 1'b0;
            awready_q <= 1'b0; bvalid_q <= 1'b0; bresp_q <= 2'h0; arready_q <= 1'b0;
            rvalid_q <= 1'b0; rresp_q <= 2'h0; rdata_q <= 32'h0000_0000;
        end
        else
        begin
            s1_q <= {ck, dqs_in, write_byte_mask, dq_in, cmd}; s2_q <= s1_q;
            ck_p_q <= ck_s; dqs_p_q <= dqs_s;
            cfg_q <= cfg_d; bank_q <= bank_d; wr_beats_q <= wr_beats_d;
            r_st_q <= r_st_d; r_cnt_q <= r_cnt_d; r_age_q <= r_age_d; r_beat_q <= r_beat_d;
            r_len_q <= r_len_d; r_bank_q <= r_bank_d; r_col_q <= r_col_d; r_ap_q <= r_ap_d;
            w_st_q <= w_st_d; w_cnt_q <= w_cnt_d; w_age_q <= w_age_d; w_beat_q <= w_beat_d; w_win_q <= w_win_d;
            w_len_q <= w_len_d; w_bank_q <= w_bank_d; w_col_q <= w_col_d; w_ap_q <= w_ap_d;
            dq_out_q <= dq_out_d; dqs_out_q <= dqs_out_d; dq_oe_q <= dq_oe_d;
            awready_q <= awready_d; bvalid_q <= bvalid_d; bresp_q <= bresp_d; arready_q <= arready_d;
            rvalid_q <= rvalid_d; rresp_q <= rresp_d; rdata_q <= rdata_d;
        end
    end

    // ----------------------------------------
    // Storage array with byte masking.
    // ----------------------------------------
    logic [8:0]  chk_a_q;
    logic [15:0] chk_old_q;
    logic [1:0]  chk_m_q;

    always_ff @(posedge aclk)
    begin
        if (w_store)
        begin
            mem_q[w_addr] <= {dm_s[1] ? mem_q[w_addr][15:8] : dq_s[15:8],
                              dm_s[0] ? mem_q[w_addr][7:0] : dq_s[7:0]}; // R14 R15
        end
        chk_a_q   <= w_addr;
        chk_old_q <= mem_q[w_addr];
        chk_m_q   <= w_store ? dm_s : 2'b00;
    end

    assign awready = awready_q;
    assign wready  = awready_q;
    assign bvalid  = bvalid_q;
    assign bresp   = bresp_q;
    assign arready = arready_q;
    assign rvalid  = rvalid_q;
    assign rresp   = rresp_q;
    assign rdata   = rdata_q;
    assign dq_out  = dq_out_q;
    assign dq_oe   = dq_oe_q;
    assign dqs_out = dqs_out_q;
    assign dqs_oe  = dq_oe_q;

    // ----------------------------------------
    // Assertions.
    // ----------------------------------------
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);

    property p_full; (r_take && (bl == `DDRBR_BL_FIX8 || (bl == `DDRBR_BL_OTF && cmd_s.bsel))) |=> r_len_q == 4'h8;
    endproperty
    a_full: assert property (p_full) // R3
        else $error("full burst not selected");
    property p_otf; (w_take && bl == `DDRBR_BL_OTF && !cmd_s.bsel) |=> w_len_q == 4'h4; endproperty
    a_otf: assert property (p_otf) // R1
        else $error("on-the-fly chop not selected");
    property p_chop; (r_take && bl == `DDRBR_BL_CHOP && cmd_s.bsel) |=> r_len_q == 4'h4; endproperty
    a_chop: assert property (p_chop) // R4
        else $error("fixed chop not honoured");
    property p_rl; $rose(dq_oe_q) |-> r_age_q == rl; endproperty
    a_rl: assert property (p_rl) // R18
        else $error("read data at wrong latency");
    property p_wl; (w_st_q == W_DATA && $past(w_st_q) == W_WAIT) |-> w_age_q == wl - 5'h01; endproperty
    a_wl: assert property (p_wl) // R21
        else $error("write window at wrong latency");
    property p_rbeats; $fell(dq_oe_q) |-> r_beat_q == r_len_q && $past(dqs_out_q) == 1'b0; endproperty
    a_rbeats: assert property (p_rbeats) // R22
        else $error("read burst beat count wrong");
    property p_mask; chk_m_q[0] |-> mem_q[chk_a_q][7:0] == chk_old_q[7:0]; endproperty
    a_mask: assert property (p_mask) // R14
        else $error("masked byte was written");
    property p_ap; (r_done && r_ap_q && !(ck_rise && cmd_s.act)) |=> !bank_q[$past(r_bank_q)]; endproperty
    a_ap: assert property (p_ap) // R5
        else $error("auto-precharge left bank open");
    property p_hang; (w_st_q == W_WAIT ##1 w_st_q == W_DATA) |-> ##[1:200] w_st_q == W_IDLE; endproperty
    a_hang: assert property (p_hang) // R13
        else $error("write window did not close");
    property p_beats; w_store |-> w_beat_q < w_len_q && w_addr[8:3] == {w_bank_q, w_col_q[5:3]}; endproperty
    a_beats: assert property (p_beats) // R12
        else $error("write beat outside its burst");

    c_rd8: cover property (r_done && r_len_q == 4'h8);
    c_rd4: cover property (r_done && r_len_q == 4'h4);
    c_wr:  cover property (w_done && w_beat_q == w_len_q);

endmodule : ddrbr_top

// [logic/ddrbr_defs.svh]
// Purpose: Offsets, field positions, reset values and codes of the burst block.
// Assumes: Included by the burst block top module only.
// Notes:   Definitions only.
`ifndef DDRBR_DEFS_SVH
`define DDRBR_DEFS_SVH

`define DDRBR_CFG_OFF   10'h000
`define DDRBR_STAT_OFF  10'h001
`define DDRBR_CNT_OFF   10'h002
`define DDRBR_BL_LSB    0
`define DDRBR_AL_LSB    4
`define DDRBR_CL_LSB    8
`define DDRBR_CWL_LSB   12
`define DDRBR_CFG_RST   16'h5600
`define DDRBR_BL_FIX8   2'h0
`define DDRBR_BL_OTF    2'h1
`define DDRBR_BL_CHOP   2'h2
`define DDRBR_LEN_FULL  4'h8
`define DDRBR_LEN_CHOP  4'h4
`define DDRBR_RESP_OK   2'h0
`define DDRBR_RESP_ERR  2'h2

`endif

// [logic/ddrbr_pkg.sv]
// Purpose: Types shared by the burst block.
// Assumes: Nothing.
// Notes:   Command fields travel together as one struct.
package ddrbr_pkg;

    typedef struct packed {
        logic       act;
        logic       pre;
        logic       rd;
        logic       wr;
        logic       ap;
        logic       bsel;
        logic [2:0] bank;
        logic [9:0] col;
    } ddrbr_cmd_t;

    typedef enum logic [1:0] {R_IDLE, R_WAIT, R_DATA} ddrbr_rst_t;
    typedef enum logic [1:0] {W_IDLE, W_WAIT, W_DATA} ddrbr_wst_t;

endpackage : ddrbr_pkg

// [sim/ddrbr_ctl_model.sv]
// Purpose: Controller model: command clock, commands and write bursts.
// Assumes: One ck period is eight aclk cycles; commands change at ck fall.
// Notes:   Idle data lines toggle; the strobe rests low between bursts.
module ddrbr_ctl_model
    import ddrbr_pkg::*;
(
    input  wire logic   aclk,
    output ddrbr_cmd_t  cmd,
    output logic        ck,
    output logic [15:0] dq_in,
    output logic [1:0]  write_byte_mask,
    output logic        dqs_in
);
    timeunit 1ns;
    timeprecision 1ps;
    int   ph  = 0;
    logic drv = 1'b0;
    initial
    begin
        {ck, cmd, dq_in, write_byte_mask, dqs_in} = '0;
    end
    always @(posedge aclk)
    begin
        ph <= (ph + 1) % 8;
        ck <= (ph + 1) % 8 < 4;
        if (!drv)
            dq_in <= ~dq_in;
    end
    // Issues one command at a ck fall; a write sends n strobe edges from rise lat.
    task automatic burst(input ddrbr_cmd_t c, input int lat, input int n,
                         input logic [15:0] d [10], input logic [1:0] m [10]);
        int h;
        do @(posedge aclk); while (ph != 3);
        cmd             <= c;
        drv             <= c.wr;
        write_byte_mask <= m[0];
        for (int e = 1; e <= 8 * lat + 4 * n + 8; e++)
        begin
            @(posedge aclk);
            h = e - 3 - 8 * lat;
            if (e == 8)
                cmd <= '0;
            if (c.wr && h >= 0 && h % 4 == 0 && h / 4 < n)
            begin
                dq_in           <= d[h / 4];
                write_byte_mask <= m[h / 4];
            end
            if (c.wr && h > 0 && h % 4 == 2 && h / 4 < n)
                dqs_in <= ~h[2];
        end
        @(posedge aclk);
        dqs_in <= 1'b0;
        drv    <= 1'b0;
    endtask : burst
endmodule : ddrbr_ctl_model

// [sim/test_ddrbr_top.sv]
// Purpose: Self-checking bench of the burst engine against a behavioural memory.
// Assumes: The controller model makes ck; aclk runs at 4 ns.
// Notes:   Bytes never written, or hit by a broken burst, are not compared.
module test_ddrbr_top
    import ddrbr_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic        aclk = 1'b0, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic        arvalid = 1'b0, rready = 1'b0, oe_p = 1'b0, dqs_p = 1'b0;
    logic [11:0] awaddr = 12'h000, araddr = 12'h000;
    logic [31:0] wdata = 32'h0000_0000, rdata, seed = 32'h0000_cb5b;
    logic [3:0]  wstrb = 4'h0;
    logic [1:0]  bresp, rresp, m_mask;
    logic        awready, wready, bvalid, arready, rvalid, ck, m_dqs, dqs_out, dq_oe, dqs_oe, dqs_w;
    logic [15:0] m_dq, dq_out, dq_w;
    logic [15:0] mem [512];
    logic [1:0]  known [512];
    logic [15:0] rq [$];
    ddrbr_cmd_t  cmd;
    int          bad_count = 0, checks_done = 0, cyc = 0, t_oe = 0, n_oe = 0;
    // ------------------------------------------------------------
    // Clock, pins and read capture.
    // ------------------------------------------------------------
    initial
    begin
        forever #2 aclk = ~aclk;
    end
    assign dq_w  = dq_oe ? dq_out : m_dq;
    assign dqs_w = dqs_oe ? dqs_out : m_dqs;
    ddrbr_top uut (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
                   .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid,
                   .rready, .ck, .cmd, .dq_in(dq_w), .write_byte_mask(m_mask), .dqs_in(dqs_w),
                   .dq_out, .dq_oe, .dqs_out, .dqs_oe);
    ddrbr_ctl_model ctl (.aclk, .cmd, .ck, .dq_in(m_dq), .write_byte_mask(m_mask), .dqs_in(m_dqs));
    always @(posedge aclk)
    begin
        cyc <= cyc + 1;
        if (dq_oe === 1'b1 && (dqs_out !== dqs_p || oe_p !== 1'b1))
            rq.push_back(dq_out);
        if (dq_oe === 1'b1 && oe_p !== 1'b1)
            t_oe = cyc;
        dqs_p <= dqs_out;
        oe_p  <= dq_oe;
        if (dqs_oe === 1'b1)
            n_oe <= n_oe + 1;
    end
    // ------------------------------------------------------------
    // Helpers.
    // ------------------------------------------------------------
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd
    function automatic int idx(input ddrbr_cmd_t c, input int len, input int b);
        return len == 8 ? int'({c.bank, c.col[5:3], 3'(b)}) : int'({c.bank, c.col[5:2], 2'(b)});
    endfunction : idx
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            bad_count++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check
    task automatic end_sim();
        if (bad_count == 0 && checks_done > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : end_sim
    task automatic axi_wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
        logic aw_on = 1'b1;
        logic w_on  = 1'b1;
        awaddr  <= a;
        wdata   <= d;
        wstrb   <= 4'hf;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        while (aw_on || w_on)
        begin
            @(posedge aclk);
            if (aw_on && awready === 1'b1)
            begin
                awvalid <= 1'b0;
                aw_on = 1'b0;
            end
            if (w_on && wready === 1'b1)
            begin
                wvalid <= 1'b0;
                w_on = 1'b0;
            end
        end
        while (bvalid !== 1'b1) @(posedge aclk);
        r = bresp;
        bready <= 1'b0;
        @(posedge aclk);
    endtask : axi_wr
    task automatic axi_rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        do @(posedge aclk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        while (rvalid !== 1'b1) @(posedge aclk);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
        @(posedge aclk);
    endtask : axi_rd
    // Writes one burst in mode f with n strobe edges (0 = whole burst), then reads it back.
    task automatic pair(input int f, input logic bs, input int n);
        ddrbr_cmd_t  c;
        logic [15:0] d [10];
        logic [1:0]  m [10];
        logic [31:0] v, c0;
        logic [1:0]  r;
        logic        ap;
        int          len, k, dl, o0;
        len = (f == 2 || (f == 1 && !bs)) ? 4 : 8;
        if (n == 0)
            n = len;
        for (int i = 0; i < 10; i++)
        begin
            d[i] = 16'(rnd());
            m[i] = n == len ? 2'(rnd()) : 2'b00;
        end
        v  = rnd();
        ap = v[0];
        axi_wr(12'h000, {16'h0000, 4'(2 + f % 2), 4'(3 + bs), 4'(f), 4'(f)}, r);
        c = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b0, bs, 3'(rnd()), 10'(rnd())};
        ctl.burst('{1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0, c.bank, 10'h000}, 2, 0, d, m);
        ctl.burst('{1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, c.bank, 10'h000}, 2, 0, d, m);
        axi_rd(12'h008, c0, r);
        ctl.burst(c, f + 2 + f % 2, n, d, m);
        axi_rd(12'h008, v, r);
        if (n != len)
            check(32'(16'(v - c0)), n < len ? n : len);
        for (int i = 0; i < len; i++)
        begin
            k = idx(c, len, i);
            if (!m[i][0]) mem[k][7:0] = d[i][7:0];
            if (!m[i][1]) mem[k][15:8] = d[i][15:8];
            known[k] = n < len ? 2'b00 : known[k] | ~m[i];
        end
        c = '{1'b0, 1'b0, 1'b1, 1'b0, ap, f == 1 ? bs : ~bs, c.bank, {~c.col[9:6], c.col[5:0]}};
        rq.delete();
        o0 = n_oe;
        ctl.burst(c, f + 3 + bs, len, d, m);
        dl = t_oe - cyc + 4 * len + 4;
        check({31'h0, dl >= 1 && dl <= 7}, 32'h0000_0001);
        check(rq.size(), len);
        check(n_oe - o0, 4 * len);
        foreach (rq[i])
        begin
            k = idx(c, len, i);
            v = {16'h0000, {8{known[k][1]}}, {8{known[k][0]}}};
            check(rq[i] & v, mem[k] & v);
        end
        ctl.burst('0, 0, 0, d, m);
        axi_rd(12'h004, v, r);
        check({31'h0, v[c.bank]}, {31'h0, ~ap});
    endtask : pair
    // ------------------------------------------------------------
    // Main sequence and watchdog.
    // ------------------------------------------------------------
    initial
    begin
        logic [31:0] v;
        logic [1:0]  r;
        for (int i = 0; i < 512; i++)
            known[i] = 2'b00;
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (4) @(posedge aclk);
        axi_rd(12'h000, v, r);
        check(v, 32'h0000_5600);
        axi_rd(12'h00c, v, r);
        check({v[31:2], r}, 32'h0000_0002);
        axi_wr(12'h00c, 32'hffff_ffff, r);
        check({30'h0, r}, 32'h0000_0002);
        for (int f = 0; f < 4; f++)
            for (int b = 0; b < 2; b++)
                pair(f, b[0], 0);
        pair(0, 1'b1, 10);
        pair(2, 1'b0, 3);
        pair(1, 1'b1, 0);
        end_sim();
    end
    initial
    begin
        repeat (30000) @(posedge aclk);
        bad_count++;
        end_sim();
    end
endmodule : test_ddrbr_top
